// File: include/cuc_pkg.sv
// Shared constants for the contrast up/down counter block
package cuc_pkg;
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned CODE_W          = 6;
	localparam logic [5:0]  CODE_MID        = 6'h20;
	localparam logic [5:0]  CODE_MAX        = 6'h3F;
	localparam logic [5:0]  CODE_MIN        = 6'h00;
	localparam int unsigned WAKE_US         = 100;
	localparam int unsigned TEMP_MS         = 50;
	localparam int unsigned RAIL_US         = 60;
	localparam int unsigned WAKE_CYC        = WAKE_US * (CLK_HZ / 1000000);
	localparam int unsigned TEMP_CYC        = TEMP_MS * (CLK_HZ / 1000);
	localparam int unsigned RAIL_CYC        = RAIL_US * (CLK_HZ / 1000000);
	localparam int unsigned CNT_W           = 21;
	localparam int unsigned REG_ADDR_W      = 4;
	localparam logic [3:0]  REG_CODE        = 4'h0;
	localparam logic [3:0]  REG_STATUS      = 4'h1;
	localparam logic [3:0]  REG_CMD         = 4'h2;
	localparam int unsigned ST_BIAS_POS     = 0;
	localparam int unsigned ST_XMIT_POS     = 1;
	localparam int unsigned ST_RAIL_POS     = 2;
	localparam int unsigned ST_READY_POS    = 3;
	localparam int unsigned ST_TEMP_POS     = 4;
	localparam int unsigned CMD_MID_POS     = 0;
	typedef enum logic [1:0] {
		CUC_OFF,
		CUC_WAKE,
		CUC_ON
	} cuc_pwr_t;
endpackage

// File: core/cuc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module cuc_sync
	import cuc_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic pin,
	output logic      level
);
	logic [2:0] stage;
	logic       next_level;

	always_comb begin
		next_level = level;
		if (stage[1] == stage[2]) begin
			next_level = stage[2];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage <= {3{RST_VAL}};
			level <= RST_VAL;
		end else begin
			stage <= {stage[1:0], pin};
			level <= next_level;
		end
	end
endmodule // cuc_sync

// File: core/cuc_top.sv
// Contrast counter, shutdown gating and wake-up tracking
// Behaviour
// RQ1: Raise falling edge with lower high increments
// RQ2: Lower falling edge with raise high decrements
// RQ3: Both adjust inputs low loads midscale
// RQ4: Adjust inputs act on edges only (both held low loads midscale as a level, every cycle)
// RQ5: No debouncing; every edge counts (the cuc_sync agreement filter drops pulses shorter than two clocks)
// RQ6: Driver must present clean logic edges
// RQ7: Both shutdowns low turns bias off
// RQ8: Bias shutdown high enables bias, regulator
// RQ9: Transmit shutdown low disables transmitters
// RQ10: Ready after 100us; temperature after 50ms
// RQ11: Transmitters wait for rail-good condition
// RQ12: Unused shutdowns held high externally
// RQ13: Reset loads counter with midscale
// RQ14: Receivers stay active always
// RQ15: Counter six bits, 64 levels
// RQ16: Midscale is code 32
// RQ17: Counter saturates at 0 and 63
`timescale 1ns/100ps
module cuc_top
	import cuc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        raise_n,
	input  wire logic        lower_n,
	input  wire logic        bias_shutdown_n,
	input  wire logic        xmit_shutdown_n,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	output logic [5:0]       contrast_code,
	output logic             panel_bias_out,
	output logic             pump_enable,
	output logic             xmit_enable,
	output logic             recv_enable,
	output logic             outputs_ready,
	output logic             temp_settled
);
	logic       raise_s;
	logic       lower_s;
	logic       bias_s;
	logic       xmit_s;
	logic       raise_d;
	logic       lower_d;
	logic [5:0] code;
	logic [5:0] next_code;
	logic       next_raise_d;
	logic       next_lower_d;
	cuc_pwr_t   pwr;
	cuc_pwr_t   next_pwr;
	logic [CNT_W-1:0] wake_cnt;
	logic [CNT_W-1:0] next_wake_cnt;
	logic [CNT_W-1:0] temp_cnt;
	logic [CNT_W-1:0] next_temp_cnt;
	logic       next_bias;
	logic       next_pump;
	logic       next_xmit;
	logic       next_ready;
	logic       next_temp;
	logic       rail_good;
	logic [7:0] next_rdata;

	cuc_sync #(.RST_VAL(1'b1)) u_raise (
		.clk   (clk),
		.rst_b (rst_b),
		.pin   (raise_n),
		.level (raise_s)
	);

	cuc_sync #(.RST_VAL(1'b1)) u_lower (
		.clk   (clk),
		.rst_b (rst_b),
		.pin   (lower_n),
		.level (lower_s)
	);

	cuc_sync #(.RST_VAL(1'b0)) u_bias (
		.clk   (clk),
		.rst_b (rst_b),
		.pin   (bias_shutdown_n),
		.level (bias_s)
	);

	cuc_sync #(.RST_VAL(1'b0)) u_xmit (
		.clk   (clk),
		.rst_b (rst_b),
		.pin   (xmit_shutdown_n),
		.level (xmit_s)
	);

	// Counter stepping on edges of the filtered adjust levels
	always_comb begin
		next_code    = code;
		next_raise_d = raise_s;
		next_lower_d = lower_s;
		if (!raise_s && !lower_s) begin
			next_code = CODE_MID; // [RQ3] [RQ16]
		end else if (raise_d && !raise_s && lower_s) begin // [RQ4] [RQ5]
			if (code != CODE_MAX) begin // [RQ17]
				next_code = code + 6'h01; // [RQ1] [RQ15]
			end
		end else if (lower_d && !lower_s && raise_s) begin // [RQ4] [RQ5]
			if (code != CODE_MIN) begin // [RQ17]
				next_code = code - 6'h01; // [RQ2] [RQ15]
			end
		end
		if (reg_wr && reg_addr == REG_CODE) begin
			next_code = reg_wdata[5:0];
		end
		if (reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_MID_POS]) begin
			next_code = CODE_MID; // [RQ16]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			code    <= CODE_MID; // [RQ13]
			raise_d <= 1'b1;
			lower_d <= 1'b1;
		end else begin
			code    <= next_code;
			raise_d <= next_raise_d;
			lower_d <= next_lower_d;
		end
	end

	// Power sequencing after shutdown release
	assign rail_good = (wake_cnt >= CNT_W'(RAIL_CYC));

	always_comb begin
		next_pwr      = pwr;
		next_wake_cnt = wake_cnt;
		next_temp_cnt = temp_cnt;
		if (!bias_s && !xmit_s) begin
			next_pwr      = CUC_OFF; // [RQ7]
			next_wake_cnt = '0;
			next_temp_cnt = '0;
		end else begin
			case (pwr)
				CUC_OFF: begin
					next_pwr = CUC_WAKE;
				end
				CUC_WAKE: begin
					next_wake_cnt = wake_cnt + CNT_W'(1);
					if (wake_cnt == CNT_W'(WAKE_CYC - 1)) begin
						next_pwr = CUC_ON; // [RQ10]
					end
				end
				CUC_ON: begin
					next_pwr = CUC_ON;
				end
				default: begin
					next_pwr = CUC_OFF;
				end
			endcase
			if (pwr != CUC_OFF && temp_cnt != CNT_W'(TEMP_CYC)) begin
				next_temp_cnt = temp_cnt + CNT_W'(1); // [RQ10]
			end
		end
		next_pump  = (bias_s || xmit_s); // [RQ7]
		next_bias  = bias_s; // [RQ8]
		next_xmit  = xmit_s && (rail_good || pwr == CUC_ON); // [RQ9] [RQ11]
		next_ready = (next_pwr == CUC_ON); // [RQ10]
		next_temp  = (temp_cnt == CNT_W'(TEMP_CYC)) && bias_s; // [RQ10]
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pwr            <= CUC_OFF;
			wake_cnt       <= '0;
			temp_cnt       <= '0;
			panel_bias_out <= 1'b0;
			pump_enable    <= 1'b0;
			xmit_enable    <= 1'b0;
			outputs_ready  <= 1'b0;
			temp_settled   <= 1'b0;
			recv_enable    <= 1'b1;
		end else begin
			pwr            <= next_pwr;
			wake_cnt       <= next_wake_cnt;
			temp_cnt       <= next_temp_cnt;
			panel_bias_out <= next_bias;
			pump_enable    <= next_pump;
			xmit_enable    <= next_xmit;
			outputs_ready  <= next_ready;
			temp_settled   <= next_temp;
			recv_enable    <= 1'b1; // [RQ14]
		end
	end

	// Register read port, data one cycle after the strobe
	always_comb begin
		next_rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				REG_CODE: begin
					next_rdata = {2'b00, code};
				end
				REG_STATUS: begin
					next_rdata[ST_BIAS_POS]  = panel_bias_out;
					next_rdata[ST_XMIT_POS]  = xmit_enable;
					next_rdata[ST_RAIL_POS]  = rail_good;
					next_rdata[ST_READY_POS] = outputs_ready;
					next_rdata[ST_TEMP_POS]  = temp_settled;
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata     <= 8'h00;
			contrast_code <= CODE_MID;
		end else begin
			reg_rdata     <= next_rdata;
			contrast_code <= next_code;
		end
	end
endmodule // cuc_top

// File: testbench/cuc_pins.sv
// Pin driver standing in for the adjust and shutdown controller
`timescale 1ns/100ps
module cuc_pins (
	input  wire logic clk,
	output logic      raise_n,
	output logic      lower_n,
	output logic      bias_shutdown_n,
	output logic      xmit_shutdown_n
);
	// Unused shutdowns idle high
	initial begin
		raise_n = 1'b1;
		lower_n = 1'b1;
		bias_shutdown_n = 1'b1;
		xmit_shutdown_n = 1'b1;
	end
	// Clean logic pulses, seven clocks low then high
	task automatic tap(input bit up, input bit dn);
		@(posedge clk);
		raise_n <= !up;
		lower_n <= !dn;
		repeat (7) @(posedge clk);
		raise_n <= 1'b1;
		lower_n <= 1'b1;
		repeat (7) @(posedge clk);
	endtask
	task automatic shut(input bit b, input bit x);
		@(posedge clk);
		bias_shutdown_n <= b;
		xmit_shutdown_n <= x;
	endtask
endmodule // cuc_pins

// File: testbench/cuc_top_properties.sv
// Port checks for the contrast counter block
`timescale 1ns/100ps
module cuc_chk
	import cuc_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       raise_n,
	input wire logic       lower_n,
	input wire logic       bias_shutdown_n,
	input wire logic       xmit_shutdown_n,
	input wire logic       panel_bias_out,
	input wire logic [3:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [5:0] contrast_code,
	input wire logic       pump_enable,
	input wire logic       xmit_enable,
	input wire logic       recv_enable,
	input wire logic       outputs_ready,
	input wire logic       temp_settled
);
	logic [20:0] on_cnt;
	logic [20:0] next_on_cnt;
	always_comb
		next_on_cnt = pump_enable ? on_cnt + {20'h0, ~&on_cnt} : '0;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b) on_cnt <= '0;
		else on_cnt <= next_on_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_both_low;
		(!raise_n && !lower_n && !reg_wr)[*6];
	endsequence
	sequence s_shut_both;
		(!bias_shutdown_n && !xmit_shutdown_n)[*6];
	endsequence
	property p_mid; s_both_low |-> contrast_code == CODE_MID; endproperty
	property p_off;
		s_shut_both |-> !pump_enable && !outputs_ready;
	endproperty
	property p_bias; (bias_shutdown_n)[*6] |=> panel_bias_out; endproperty
	property p_sat;
		contrast_code == CODE_MAX && !reg_wr |=> contrast_code != CODE_MIN;
	endproperty
	property p_rd;
		reg_rd && reg_addr == REG_CODE
			|=> reg_rdata == {2'b00, $past(contrast_code)};
	endproperty
	property p_xoff; (!xmit_shutdown_n)[*6] |-> !xmit_enable; endproperty
	property p_rail; xmit_enable && pump_enable |-> on_cnt >= 1400; endproperty
	property p_rdy; outputs_ready && pump_enable |-> on_cnt >= 2400; endproperty
	property p_rdy_by; on_cnt == 2600 |-> outputs_ready; endproperty
	property p_temp;
		temp_settled && pump_enable |-> on_cnt >= 1249000;
	endproperty
	property p_rcv; recv_enable; endproperty
	a_mid: assert property (p_mid) else $error("code not midscale");
	a_sat: assert property (p_sat) else $error("code wrapped");
	a_rd: assert property (p_rd) else $error("bad code read");
	a_xoff: assert property (p_xoff) else $error("xmit on");
	a_rail: assert property (p_rail) else $error("xmit early");
	a_rdy: assert property (p_rdy) else $error("ready early");
	a_rdy_by: assert property (p_rdy_by) else $error("ready late");
	a_temp: assert property (p_temp) else $error("temp early");
	a_rcv: assert property (p_rcv) else $error("receivers off");
	a_off: assert property (p_off) else $error("pumps on");
	a_bias: assert property (p_bias) else $error("bias off");
endmodule // cuc_chk
bind cuc_top cuc_chk u_chk (.*);

// File: testbench/cuc_top_test.sv
// Self-checking bench for the contrast counter block
`timescale 1ns/100ps
`define CK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
	mismatches++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module cuc_top_test
	import cuc_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       raise_n, lower_n, bias_shutdown_n, xmit_shutdown_n;
	logic [3:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0;
	logic [7:0] reg_rdata;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [5:0] contrast_code;
	logic       panel_bias_out, pump_enable, xmit_enable;
	logic       recv_enable, outputs_ready, temp_settled;
	int         mismatches = 0, n_compared = 0, cyc = 0, m = 32, v;
	always #20 clk = !clk;
	cuc_pins pins (.*);
	cuc_top uut (.*);
	task automatic give_verdict();
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic step(input bit up, input bit dn);
		pins.tap(up, dn);
		if (up && dn) m = 32;
		else if (up) m = (m < 63) ? m + 1 : 63;
		else m = (m > 0) ? m - 1 : 0;
		`CK("code", m[5:0], contrast_code)
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 `CK("rdata", e, reg_rdata)
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic outs(input logic [3:0] e);
		logic [3:0] seen;
		@(posedge clk);
		#1;
		seen = {panel_bias_out, pump_enable, xmit_enable,
			outputs_ready};
		`CK("outs", e, seen)
		`CK("temp", 1'b0, temp_settled)
		`CK("recv", 1'b1, recv_enable)
	endtask
	initial begin
		void'($urandom(32'h78CF4BBF));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		`CK("reset code", 6'h20, contrast_code)
		repeat (40) step(1, 0);
		repeat (70) step(0, 1);
		repeat (60) begin
			v = $urandom_range(2, 0);
			step(v != 1, v != 0);
		end
		step(1, 1);
		v = $urandom_range(63, 0);
		wr(REG_CODE, 8'(v));
		rd(REG_CODE, 8'(v));
		wr(REG_CMD, 8'h01);
		rd(REG_CODE, 8'h20);
		wr(REG_STATUS, 8'h3F);
		rd(REG_CODE, 8'h20);
		rd(4'hF, 8'h00);
		pins.shut(0, 0);
		repeat (10) @(posedge clk);
		outs(4'h0);
		pins.shut(1, 0);
		repeat (2600) @(posedge clk);
		outs(4'hD);
		rd(REG_STATUS, 8'h0D);
		pins.shut(0, 0);
		repeat (10) @(posedge clk);
		pins.shut(0, 1);
		repeat (1000) @(posedge clk);
		outs(4'h4);
		repeat (700) @(posedge clk);
		outs(4'h6);
		rd(REG_STATUS, 8'h06);
		give_verdict();
	end
endmodule // cuc_top_test
